// ==== cmpo_top.sv ====
// Comparator output control: APB registers, edge detection, input routing
// How it works
// RULE_01 - Timer-lock mode passes result through latch
// RULE_02 - Latch captures on gate timer clock fall
// RULE_03 - Timer counts on rising edge, no race
// RULE_04 - Latch uses prescaled timer clock
// RULE_05 - Separate rising and falling edge detectors
// RULE_06 - Enabled detector firing sets interrupt flag
// RULE_07 - Software enables all bits for interrupts
// RULE_08 - Software alone clears the flag
// RULE_09 - Edge during clear keeps flag set
// RULE_10 - Polarity or enable change makes edges
// RULE_11 - Plus select routes pins, DAC, reference, ground
// RULE_12 - Minus select routes four pins, reference, ground
// RULE_13 - Disabled comparator disconnects every input
// RULE_14 - Result offered as gate timer source
// RULE_15 - Software should lock when gating a timer
// RULE_16 - Polarity bit inverts result everywhere
// RULE_17 - Disabled comparator draws no active power
// RULE_18 - Lock select is control bit zero
// RULE_19 - Result synchronised by two flops
// RULE_20 - Select codes in listed order, rest ground
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
module cmpo_top
	import cmpo_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic CMP_RAW,
	input wire logic TMR_CLK,
	output logic CMP_POWER,
	output logic HYST_EN,
	output logic PLUS_CONNECT,
	output logic MINUS_CONNECT,
	output logic [2:0] PLUS_SEL,
	output logic [2:0] MINUS_SEL,
	output logic CMP_OUT,
	output logic GATE_SRC,
	output logic IRQ_FLAG,
	output logic IRQ_REQ
);
	typedef struct packed
	{
		logic [7:0] ctrl;
		logic [1:0] edge_en;
		logic [2:0] plus_sel;
		logic [2:0] minus_sel;
		logic flag;
		logic irq_en;
		logic res_prev;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic power;
		logic hyst;
		logic plus_con;
		logic minus_con;
		logic [2:0] plus_out;
		logic [2:0] minus_out;
		logic cmp_out;
		logic gate;
		logic irq_flag;
		logic irq_req;
	} cmpo_state_type;

	cmpo_state_type s_q;
	cmpo_state_type s_d;
	logic rst_s1_q;
	logic rst_s2_q;
	logic result;
	logic access;
	logic wr;
	logic rise;
	logic fall;
	logic edge_hit;
	logic flag_clr;
	logic mapped;
	logic [31:0] rdata;

	cmpo_link_if lnk();

	// ==========================================
	// Code mapping: unused codes fall back to ground
	function automatic logic [2:0] plus_code(input logic [2:0] c);
		plus_code = (c > CMPO_P_GND) ? CMPO_P_GND : c; // RULE_20
	endfunction

	function automatic logic [2:0] minus_code(input logic [2:0] c);
		minus_code = (c > CMPO_N_GND) ? CMPO_N_GND : c; // RULE_20
	endfunction

	// ==========================================
	// Reset release through two flops
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// ==========================================
	// Retiming stage
	cmpo_retime u_retime
	(
		.clk(CLK),
		.rst_n(rst_s2_q),
		.cmp_raw(CMP_RAW),
		.tmr_clk(TMR_CLK),
		.lnk(lnk.stage)
	);

	assign lnk.on = s_q.ctrl[CMPO_ON_BIT];
	assign lnk.invert = s_q.ctrl[CMPO_INV_BIT];
	assign lnk.lock = s_q.ctrl[CMPO_LOCK_BIT]; // RULE_18
	assign result = lnk.result;

	// ==========================================
	// Bus decode; read data is captured on the first access cycle,
	// a write lands only on the edge that ends the access, ready high
	assign access = PSEL & PENABLE & ~s_q.pready;
	assign wr = PSEL & PENABLE & PWRITE & s_q.pready;
	assign mapped = (PADDR == CMPO_CTRL_OFS) | (PADDR == CMPO_EDGE_OFS)
		| (PADDR == CMPO_PLUS_OFS) | (PADDR == CMPO_MINUS_OFS)
		| (PADDR == CMPO_FLAG_OFS);

	// Read mux, reserved bits read zero except control bit 2, which reads one
	always_comb
	begin
		rdata = '0;
		case (PADDR)
			CMPO_CTRL_OFS:
			begin
				rdata[7:0] = s_q.ctrl | CMPO_CTRL_FIXED;
				rdata[CMPO_RES_BIT] = result;
			end
			CMPO_EDGE_OFS: rdata[1:0] = s_q.edge_en;
			CMPO_PLUS_OFS: rdata[2:0] = s_q.plus_sel;
			CMPO_MINUS_OFS: rdata[2:0] = s_q.minus_sel;
			CMPO_FLAG_OFS:
			begin
				rdata[CMPO_FLAG_BIT] = s_q.flag;
				rdata[CMPO_IEN_BIT] = s_q.irq_en;
			end
			default: rdata = '0;
		endcase
	end

	// ==========================================
	// Edge detectors on the synchronised, polarity-adjusted result
	assign rise = result & ~s_q.res_prev; // RULE_05 RULE_10
	assign fall = ~result & s_q.res_prev; // RULE_05 RULE_10
	assign edge_hit = (rise & s_q.edge_en[CMPO_RISE_BIT])
		| (fall & s_q.edge_en[CMPO_FALL_BIT]); // RULE_06
	assign flag_clr = wr & (PADDR == CMPO_FLAG_OFS) & PWDATA[CMPO_FLAG_BIT];

	// ==========================================
	// Next state
	always_comb
	begin
		s_d = s_q;
		s_d.res_prev = result;
		s_d.pready = access;
		s_d.pslverr = access & ~mapped;
		if (access)
		begin
			s_d.prdata = PWRITE ? 32'h0000_0000 : rdata;
		end
		if (wr)
		begin
			case (PADDR)
				CMPO_CTRL_OFS:
				begin
					s_d.ctrl = PWDATA[7:0] & ~CMPO_CTRL_FIXED;
					s_d.ctrl[CMPO_RES_BIT] = 1'b0;
					s_d.ctrl[5] = 1'b0;
					s_d.ctrl[3] = 1'b0;
				end
				CMPO_EDGE_OFS: s_d.edge_en = PWDATA[1:0];
				CMPO_PLUS_OFS: s_d.plus_sel = PWDATA[2:0];
				CMPO_MINUS_OFS: s_d.minus_sel = PWDATA[2:0];
				CMPO_FLAG_OFS: s_d.irq_en = PWDATA[CMPO_IEN_BIT];
				default: s_d.prdata = '0;
			endcase
		end
		// Write-one clears, but a same-cycle edge wins
		if (flag_clr)
		begin
			s_d.flag = 1'b0; // RULE_08
		end
		if (edge_hit)
		begin
			s_d.flag = 1'b1; // RULE_06 RULE_09
		end
		// Control and flag outputs follow the next register values so no extra lag; CMP_OUT and GATE_SRC take result one cycle late
		s_d.power = s_d.ctrl[CMPO_ON_BIT]; // RULE_17
		s_d.hyst = s_d.ctrl[CMPO_HYS_BIT];
		s_d.plus_con = s_d.ctrl[CMPO_ON_BIT]; // RULE_13
		s_d.minus_con = s_d.ctrl[CMPO_ON_BIT]; // RULE_13
		// Ground code while off too, in case the switch lags the connect
		s_d.plus_out = s_d.ctrl[CMPO_ON_BIT] ? plus_code(s_d.plus_sel) : CMPO_P_GND; // RULE_11
		s_d.minus_out = s_d.ctrl[CMPO_ON_BIT] ? minus_code(s_d.minus_sel) : CMPO_N_GND; // RULE_12
		s_d.cmp_out = result;
		s_d.gate = result; // RULE_14
		s_d.irq_flag = s_d.flag;
		s_d.irq_req = s_d.flag & s_d.irq_en;
	end

	// Registered state
	always_ff @(posedge CLK or negedge rst_s2_q)
	begin
		if (!rst_s2_q)
		begin
			s_q <= '0;
			s_q.ctrl <= CMPO_CTRL_RST;
			s_q.edge_en <= CMPO_EDGE_RST;
			s_q.plus_sel <= CMPO_SEL_RST;
			s_q.minus_sel <= CMPO_SEL_RST;
			s_q.plus_out <= CMPO_P_GND;
			s_q.minus_out <= CMPO_N_GND;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// Outputs straight from flops
	assign PRDATA = s_q.prdata;
	assign PREADY = s_q.pready;
	assign PSLVERR = s_q.pslverr;
	assign CMP_POWER = s_q.power;
	assign HYST_EN = s_q.hyst;
	assign PLUS_CONNECT = s_q.plus_con;
	assign MINUS_CONNECT = s_q.minus_con;
	assign PLUS_SEL = s_q.plus_out;
	assign MINUS_SEL = s_q.minus_out;
	assign CMP_OUT = s_q.cmp_out;
	assign GATE_SRC = s_q.gate;
	assign IRQ_FLAG = s_q.irq_flag;
	assign IRQ_REQ = s_q.irq_req;

	// ==========================================
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rst_s2_q);

	sequence rise_seen;
		rise & s_q.edge_en[CMPO_RISE_BIT];
	endsequence

	sequence fall_seen;
		fall & s_q.edge_en[CMPO_FALL_BIT];
	endsequence

	sequence apb_wait;
		PSEL & PENABLE & !PREADY;
	endsequence

	rise_flag_a: assert property (rise_seen |=> IRQ_FLAG) // RULE_06
		else $error("rising edge did not set flag");
	fall_flag_a: assert property (fall_seen |=> IRQ_FLAG) // RULE_05
		else $error("falling edge did not set flag");
	set_wins_a: assert property (edge_hit && flag_clr |=> IRQ_FLAG) // RULE_09
		else $error("clear beat a same-cycle edge");
	flag_sticky_a: assert property (IRQ_FLAG && !flag_clr |=> IRQ_FLAG) // RULE_08
		else $error("flag cleared without software");
	no_edge_a: assert property (!edge_hit && !IRQ_FLAG |=> !IRQ_FLAG) // RULE_06
		else $error("flag set without enabled edge");
	inputs_off_a: assert property (!CMP_POWER |-> !PLUS_CONNECT && !MINUS_CONNECT) // RULE_13
		else $error("inputs connected while comparator off");
	plus_map_a: assert property (CMP_POWER && s_q.plus_sel > CMPO_P_GND
		|-> PLUS_SEL == CMPO_P_GND) // RULE_20
		else $error("unused plus code not grounded");
	minus_map_a: assert property (CMP_POWER |-> MINUS_SEL == minus_code(s_q.minus_sel)) // RULE_12
		else $error("minus routing wrong");
	power_write_a: assert property (wr && PADDR == CMPO_CTRL_OFS
		|=> CMP_POWER == $past(PWDATA[CMPO_ON_BIT])) // RULE_17
		else $error("power did not follow enable write");
	apb_ready_a: assert property (apb_wait |=> PREADY ##1 !PREADY)
		else $error("ready not one cycle after access");
	gate_follow_a: assert property (##1 GATE_SRC == $past(result)) // RULE_14
		else $error("gate source not tracking result");
endmodule

// ==== cmpo_pkg.sv ====
// Shared constants for the comparator output control block
package cmpo_pkg;
	// ==========================================
	// Register offsets (byte addresses)
	localparam logic [7:0] CMPO_CTRL_OFS = 8'h00;
	localparam logic [7:0] CMPO_EDGE_OFS = 8'h04;
	localparam logic [7:0] CMPO_PLUS_OFS = 8'h08;
	localparam logic [7:0] CMPO_MINUS_OFS = 8'h0C;
	localparam logic [7:0] CMPO_FLAG_OFS = 8'h10;
	// ==========================================
	// Bit positions
	localparam int CMPO_LOCK_BIT = 0;
	localparam int CMPO_HYS_BIT = 1;
	localparam int CMPO_INV_BIT = 4;
	localparam int CMPO_RES_BIT = 6;
	localparam int CMPO_ON_BIT = 7;
	localparam int CMPO_FALL_BIT = 0;
	localparam int CMPO_RISE_BIT = 1;
	localparam int CMPO_FLAG_BIT = 0;
	localparam int CMPO_IEN_BIT = 1;
	// Unimplemented control bit that reads as one
	localparam logic [7:0] CMPO_CTRL_FIXED = 8'h04;
	// ==========================================
	// Reset values
	localparam logic [7:0] CMPO_CTRL_RST = 8'h00;
	localparam logic [1:0] CMPO_EDGE_RST = 2'h0;
	localparam logic [2:0] CMPO_SEL_RST = 3'h0;
	// ==========================================
	// Input select codes
	localparam logic [2:0] CMPO_P_IN0 = 3'h0;
	localparam logic [2:0] CMPO_P_IN1 = 3'h1;
	localparam logic [2:0] CMPO_P_DAC = 3'h2;
	localparam logic [2:0] CMPO_P_REF = 3'h3;
	localparam logic [2:0] CMPO_P_GND = 3'h4;
	localparam logic [2:0] CMPO_N_REF = 3'h4;
	localparam logic [2:0] CMPO_N_GND = 3'h5;
endpackage

// ==== cmpo_link_if.sv ====
// Connection between the control top and the result retiming stage
`timescale 1ns/1ps
interface cmpo_link_if;
	logic on;
	logic invert;
	logic lock;
	logic result;
	modport ctrl
	(
		output on,
		output invert,
		output lock,
		input result
	);
	modport stage
	(
		input on,
		input invert,
		input lock,
		output result
	);
endinterface

// ==== cmpo_retime.sv ====
// Result synchroniser, polarity stage and timer-locked latch
`timescale 1ns/1ps
module cmpo_retime
	import cmpo_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cmp_raw,
	input wire logic tmr_clk,
	cmpo_link_if.stage lnk
);
	typedef struct packed
	{
		logic raw_s1;
		logic raw_s2;
		logic tck_s1;
		logic tck_s2;
		logic tck_prev;
		logic latch;
		logic result;
	} cmpo_rt_type;

	cmpo_rt_type s_q;
	cmpo_rt_type s_d;
	logic adj_res;
	logic tck_fall;

	// ==========================================
	// Next state
	always_comb
	begin
		s_d = s_q;
		// Both pins are asynchronous, so two flops each before use
		s_d.raw_s1 = cmp_raw; // RULE_19
		s_d.raw_s2 = s_q.raw_s1;
		s_d.tck_s1 = tmr_clk;
		s_d.tck_s2 = s_q.tck_s1;
		s_d.tck_prev = s_q.tck_s2;
		// Disabled core reads as zero, so polarity still makes edges
		adj_res = (lnk.on & s_q.raw_s2) ^ lnk.invert; // RULE_16 RULE_17
		// Timer input is already prescaled; capture on its fall only
		tck_fall = s_q.tck_prev & ~s_q.tck_s2; // RULE_04
		// Timer counts on rise, so the fall keeps the two apart
		if (tck_fall) // RULE_02 RULE_03
		begin
			s_d.latch = adj_res;
		end
		s_d.result = lnk.lock ? s_d.latch : adj_res; // RULE_01
	end

	// Registered state
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign lnk.result = s_q.result;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	latch_capture_a: assert property (tck_fall |=> s_q.latch == $past(adj_res)) // RULE_02
		else $error("latch missed timer falling edge");
	latch_hold_a: assert property (!tck_fall |=> $stable(s_q.latch)) // RULE_04
		else $error("latch moved without timer falling edge");
	locked_path_a: assert property (lnk.lock |=> s_q.result == s_q.latch) // RULE_01
		else $error("locked result bypassed the latch");
endmodule

// ==== cmpo_core_model.sv ====
// Behavioural comparator core and prescaled gate timer clock
`timescale 1ns/1ps
module cmpo_core_model
(
	input wire logic clk,
	input wire logic level,
	input wire logic run,
	output logic cmp_raw,
	output logic tmr_clk
);
	logic [1:0] div_q;
	initial
	begin
		cmp_raw = 1'b0;
		tmr_clk = 1'b1;
		div_q = 2'h0;
	end
	// Three cycles a half period; parks high when stopped so the latch cannot fire
	always @(posedge clk)
	begin
		cmp_raw <= level;
		div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
		if ((run || !tmr_clk) && div_q == 2'h2)
			tmr_clk <= !tmr_clk;
	end
endmodule

// ==== comparator_output_control_tb_top.sv ====
// Self-checking bench for the comparator output control block
`timescale 1ns/1ps
module comparator_output_control_tb_top;
	import cmpo_pkg::*;
	logic CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0, PRDATA, rd;
	logic PREADY, PSLVERR, CMP_RAW, TMR_CLK, CMP_POWER, HYST_EN, PLUS_CONNECT;
	logic MINUS_CONNECT, CMP_OUT, GATE_SRC, IRQ_FLAG, IRQ_REQ, err, level = 1'b0, run = 1'b0;
	logic [2:0] PLUS_SEL, MINUS_SEL;
	int mismatches = 0, checks = 0;
	cmpo_top cmpo_top_i (.CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .CMP_RAW(CMP_RAW), .TMR_CLK(TMR_CLK), .CMP_POWER(CMP_POWER),
		.HYST_EN(HYST_EN), .PLUS_CONNECT(PLUS_CONNECT), .MINUS_CONNECT(MINUS_CONNECT),
		.PLUS_SEL(PLUS_SEL), .MINUS_SEL(MINUS_SEL), .CMP_OUT(CMP_OUT), .GATE_SRC(GATE_SRC),
		.IRQ_FLAG(IRQ_FLAG), .IRQ_REQ(IRQ_REQ));
	cmpo_core_model cmpo_core_model_i (.clk(CLK), .level(level), .run(run),
		.cmp_raw(CMP_RAW), .tmr_clk(TMR_CLK));
	// 50 MHz system clock
	always #10 CLK = ~CLK;
	task automatic tally_and_finish();
		if (mismatches == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One APB transfer; request held until ready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		// No cycle count assumed; only the watchdog ends a hang
		do
		begin
			@(posedge CLK);
		end
		while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(negedge CLK);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge CLK);
		@(negedge CLK);
	endtask
	// Flag must still be up, then software clears it, keeping the irq enable
	task automatic flag_clear(input logic exp);
		chk("flag", exp, IRQ_FLAG);
		apb(1'b1, CMPO_FLAG_OFS, 32'h3);
		settle(1);
		chk("flag_clr", 1'b0, IRQ_FLAG);
		@(posedge CLK);
	endtask
	initial
	begin
		#100000;
		mismatches++;
		tally_and_finish();
	end
	initial
	begin
		repeat (16) @(posedge CLK);
		RST_B <= 1'b1;
		repeat (4) @(posedge CLK);
		apb(1'b0, CMPO_CTRL_OFS, 32'h0);
		chk("ctrl_rst", CMPO_CTRL_RST | CMPO_CTRL_FIXED, rd);
		chk("ok_err", 1'b0, err);
		chk("sel_rst", 8'h25, {PLUS_CONNECT, MINUS_CONNECT, PLUS_SEL, MINUS_SEL});
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped_err", 1'b1, err);
		chk("unmapped_rd", 32'h0, rd);
		apb(1'b1, CMPO_EDGE_OFS, 32'h3);
		apb(1'b1, CMPO_FLAG_OFS, 32'h2);
		apb(1'b1, CMPO_CTRL_OFS, 32'h82);
		chk("power", 2'h3, {CMP_POWER, HYST_EN});
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b1, CMPO_PLUS_OFS, i);
			apb(1'b1, CMPO_MINUS_OFS, i);
			chk("plus", (i > 4) ? 4 : i, PLUS_SEL);
			chk("minus", (i > 5) ? 5 : i, MINUS_SEL);
			chk("connect", 2'h3, {PLUS_CONNECT, MINUS_CONNECT});
			apb(1'b0, CMPO_PLUS_OFS, 32'h0);
			chk("plus_rd", i, rd);
		end
		chk("flag_idle", 1'b0, IRQ_FLAG);
		level <= 1'b1;
		settle(6);
		chk("out_rise", 3'h7, {CMP_OUT, GATE_SRC, IRQ_REQ});
		apb(1'b0, CMPO_CTRL_OFS, 32'h0);
		chk("ctrl_res", 32'hC6, rd);
		flag_clear(1'b1);
		apb(1'b1, CMPO_CTRL_OFS, 32'h92);
		settle(6);
		chk("out_inv", 1'b0, CMP_OUT);
		flag_clear(1'b1);
		apb(1'b1, CMPO_EDGE_OFS, 32'h2);
		apb(1'b1, CMPO_CTRL_OFS, 32'h82);
		settle(6);
		flag_clear(1'b1);
		apb(1'b1, CMPO_CTRL_OFS, 32'h92);
		settle(6);
		chk("fall_masked", 2'h0, {CMP_OUT, IRQ_FLAG});
		apb(1'b1, CMPO_CTRL_OFS, 32'h12);
		settle(6);
		chk("off_out", 1'b1, CMP_OUT);
		chk("off_sel", 9'h025, {CMP_POWER, PLUS_CONNECT, MINUS_CONNECT, PLUS_SEL, MINUS_SEL});
		flag_clear(1'b1);
		level <= 1'b0;
		run <= 1'b1;
		apb(1'b1, CMPO_CTRL_OFS, 32'h81);
		settle(12);
		chk("lock_low", 1'b0, CMP_OUT);
		run <= 1'b0;
		settle(8);
		level <= 1'b1;
		settle(10);
		chk("lock_hold", 1'b0, CMP_OUT);
		run <= 1'b1;
		settle(12);
		chk("lock_fall", 2'h3, {CMP_OUT, GATE_SRC});
		apb(1'b1, CMPO_CTRL_OFS, 32'h80);
		level <= 1'b0;
		settle(6);
		flag_clear(1'b1);
		// Rise reaches the detector on the very edge that ends the clearing write
		level <= 1'b1;
		@(posedge CLK);
		apb(1'b1, CMPO_FLAG_OFS, 32'h3);
		settle(1);
		chk("set_wins", 1'b1, IRQ_FLAG);
		tally_and_finish();
	end
endmodule
